// ===== ep_pkg.sv
// Constants and types for the endpoint response and lock logic
package ep_pkg;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_DISABLE   = 4'h0;
    localparam logic [3:0] MODE_NAK_IO    = 4'h1;
    localparam logic [3:0] MODE_ST_OUT    = 4'h2;
    localparam logic [3:0] MODE_STALL_IO  = 4'h3;
    localparam logic [3:0] MODE_IGN_IO    = 4'h4;
    localparam logic [3:0] MODE_ISO_OUT   = 4'h5;
    localparam logic [3:0] MODE_ST_IN     = 4'h6;
    localparam logic [3:0] MODE_ISO_IN    = 4'h7;
    localparam logic [3:0] MODE_NAK_OUT   = 4'h8;
    localparam logic [3:0] MODE_ACK_OUT   = 4'h9;
    localparam logic [3:0] MODE_NAK_O_SI  = 4'ha;
    localparam logic [3:0] MODE_ACK_O_SI  = 4'hb;
    localparam logic [3:0] MODE_NAK_IN    = 4'hc;
    localparam logic [3:0] MODE_ACK_IN    = 4'hd;
    localparam logic [3:0] MODE_NAK_I_SO  = 4'he;
    localparam logic [3:0] MODE_ACK_I_SO  = 4'hf;

    // ------------------------------------------------------------
    // Field positions, reset values, counts
    // ------------------------------------------------------------
    localparam int         SETUP_BIT  = 7;
    localparam int         STALL_BIT  = 7;
    localparam int         IN_BIT     = 6;
    localparam int         OUT_BIT    = 5;
    localparam int         ACK_BIT    = 4;
    localparam int         TOGGLE_BIT = 7;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [5:0] CRC_BYTES  = 6'h02;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_EP0_MODE = 5'h00;
    localparam logic [4:0] OFS_EP0_CNT  = 5'h04;
    localparam logic [4:0] OFS_EP1_MODE = 5'h08;
    localparam logic [4:0] OFS_EP1_CNT  = 5'h0c;
    localparam logic [4:0] OFS_FLAGS    = 5'h10;

    // ------------------------------------------------------------
    // Tokens and responses
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TOK_SETUP = 2'h0,
        TOK_IN    = 2'h1,
        TOK_OUT   = 2'h2
    } tok_t;

    typedef enum logic [2:0] {
        RSP_NONE   = 3'h0,
        RSP_ACK    = 3'h1,
        RSP_NAK    = 3'h2,
        RSP_STALL  = 3'h3,
        RSP_DATA   = 3'h4,
        RSP_ZLP    = 3'h5,
        RSP_CHECK  = 3'h6,
        RSP_ALWAYS = 3'h7
    } rsp_t;

    typedef struct packed {
        logic acc;
        rsp_t in_r;
        rsp_t out_r;
    } row_t;

endpackage

// ===== ep_rsp_if.sv
// Carrier between the engine and the mode decoder
`timescale 1ns/10ps
`default_nettype none
interface ep_rsp_if;
    logic         [3:0] mode;
    ep_pkg::tok_t       tok;
    logic               stall;
    logic               ctrl;
    logic               crc_ok;
    logic               chk_ok;
    logic               host_ack;
    ep_pkg::rsp_t       rsp;
    logic         [3:0] next_mode;
    logic               engaged;
    logic               acked;
    modport engine  (output mode, tok, stall, ctrl, crc_ok, chk_ok, host_ack,
                     input rsp, next_mode, engaged, acked);
    modport decoder (input mode, tok, stall, ctrl, crc_ok, chk_ok, host_ack,
                     output rsp, next_mode, engaged, acked);
endinterface
`default_nettype wire

// ===== reg_lock.sv
// Write lock flag for one endpoint 0 register
`timescale 1ns/10ps
`default_nettype none
module reg_lock (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clear_i,
    output logic      locked_o
);
    typedef struct packed {
        logic locked;
    } lock_t;

    lock_t q;
    lock_t d;

    always_comb
    begin
        d = q;
        d.locked = set_i | (q.locked & ~clear_i);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign locked_o = q.locked;
endmodule // reg_lock
`default_nettype wire

// ===== mode_decoder.sv
// Token response and automatic mode change from the mode code
`timescale 1ns/10ps
`default_nettype none
module mode_decoder (
    ep_rsp_if.decoder d
);
    ep_pkg::row_t row;
    logic         auto_chg;

    always_comb
    begin
        case (d.mode)
            ep_pkg::MODE_DISABLE:
                row = '{1'b0, ep_pkg::RSP_NONE, ep_pkg::RSP_NONE};
            ep_pkg::MODE_NAK_IO:
                row = '{1'b1, ep_pkg::RSP_NAK, ep_pkg::RSP_NAK};
            ep_pkg::MODE_ST_OUT:
                row = '{1'b1, ep_pkg::RSP_STALL, ep_pkg::RSP_CHECK};
            ep_pkg::MODE_STALL_IO:
                row = '{1'b1, ep_pkg::RSP_STALL, ep_pkg::RSP_STALL};
            ep_pkg::MODE_IGN_IO:
                row = '{1'b1, ep_pkg::RSP_NONE, ep_pkg::RSP_NONE};
            ep_pkg::MODE_ISO_OUT:
                row = '{1'b0, ep_pkg::RSP_NONE, ep_pkg::RSP_ALWAYS};
            ep_pkg::MODE_ST_IN:
                row = '{1'b1, ep_pkg::RSP_ZLP, ep_pkg::RSP_STALL};
            ep_pkg::MODE_ISO_IN:
                row = '{1'b0, ep_pkg::RSP_DATA, ep_pkg::RSP_NONE};
            ep_pkg::MODE_NAK_OUT:
                row = '{1'b0, ep_pkg::RSP_NONE, ep_pkg::RSP_NAK};
            ep_pkg::MODE_ACK_OUT:
                row = '{1'b0, ep_pkg::RSP_NONE, ep_pkg::RSP_ACK};
            ep_pkg::MODE_NAK_O_SI:
                row = '{1'b1, ep_pkg::RSP_ZLP, ep_pkg::RSP_NAK};
            ep_pkg::MODE_ACK_O_SI:
                row = '{1'b1, ep_pkg::RSP_ZLP, ep_pkg::RSP_ACK};
            ep_pkg::MODE_NAK_IN:
                row = '{1'b0, ep_pkg::RSP_NAK, ep_pkg::RSP_NONE};
            ep_pkg::MODE_ACK_IN:
                row = '{1'b0, ep_pkg::RSP_DATA, ep_pkg::RSP_NONE};
            ep_pkg::MODE_NAK_I_SO:
                row = '{1'b1, ep_pkg::RSP_NAK, ep_pkg::RSP_CHECK};
            default:
                row = '{1'b1, ep_pkg::RSP_DATA, ep_pkg::RSP_CHECK};
        endcase
        d.rsp = ep_pkg::RSP_NONE;
        d.engaged = 1'b0;
        d.acked = 1'b0;
        case (d.tok)
            ep_pkg::TOK_SETUP:
            begin
                d.engaged = row.acc;
                if (row.acc && d.crc_ok)
                    d.rsp = ep_pkg::RSP_ACK;
            end
            ep_pkg::TOK_IN:
            begin
                d.engaged = (row.in_r != ep_pkg::RSP_NONE);
                d.rsp = row.in_r;
                if (d.mode == ep_pkg::MODE_ACK_IN && d.stall)
                    d.rsp = ep_pkg::RSP_STALL;
                d.acked = d.host_ack && (d.rsp == ep_pkg::RSP_DATA
                          || d.rsp == ep_pkg::RSP_ZLP);
            end
            ep_pkg::TOK_OUT:
            begin
                d.engaged = (row.out_r != ep_pkg::RSP_NONE);
                d.rsp = row.out_r;
                if (row.out_r == ep_pkg::RSP_CHECK)
                    d.rsp = d.chk_ok ? ep_pkg::RSP_ACK
                                     : ep_pkg::RSP_STALL;
                if (row.out_r == ep_pkg::RSP_ALWAYS)
                    d.rsp = ep_pkg::RSP_NONE;
                if (d.mode == ep_pkg::MODE_ACK_OUT && d.stall)
                    d.rsp = ep_pkg::RSP_STALL;
                if (!d.crc_ok)
                    d.rsp = ep_pkg::RSP_NONE;
            end
            default:
                d.rsp = ep_pkg::RSP_NONE;
        endcase
        if (d.rsp == ep_pkg::RSP_ACK)
            d.acked = 1'b1;
        auto_chg = d.mode[3] && d.mode[0] && d.acked &&
                   ((d.tok == ep_pkg::TOK_OUT) ||
                    (d.mode == ep_pkg::MODE_ACK_IN));
        d.next_mode = d.mode;
        if (d.tok == ep_pkg::TOK_SETUP && d.rsp == ep_pkg::RSP_ACK && d.ctrl)
            d.next_mode = ep_pkg::MODE_NAK_IO;
        else if (auto_chg)
            d.next_mode = {d.mode[3:1], 1'b0};
    end
endmodule // mode_decoder
`default_nettype wire

// ===== ep_engine.sv
// Endpoint response engine with register file and endpoint 0 locks
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ep_engine (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic          [4:0] avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic         [31:0] avs_writedata_i,
    input  wire logic          [3:0] avs_byteenable_i,
    output logic              [31:0] avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire logic                tok_valid_i,
    input  wire ep_pkg::tok_t        tok_pid_i,
    input  wire logic                tok_ep_i,
    input  wire logic                data_start_i,
    input  wire logic                txn_end_i,
    input  wire logic          [5:0] rx_count_i,
    input  wire logic                rx_toggle_i,
    input  wire logic                crc_ok_i,
    input  wire logic                host_ack_i,
    output logic                     rsp_valid_o,
    output ep_pkg::rsp_t             rsp_code_o,
    output logic               [5:0] tx_count_o,
    output logic                     tx_toggle_o,
    output logic               [1:0] ep_flag_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } state_t;

    typedef struct packed {
        state_t             st;
        logic               ep;
        ep_pkg::tok_t       tok;
        logic               hold;
        logic         [7:0] mode0;
        logic         [7:0] cnt0;
        logic         [7:0] mode1;
        logic         [7:0] cnt1;
        logic         [1:0] flags;
        logic               ack;
        logic         [7:0] rdata;
        logic               rv;
        ep_pkg::rsp_t       rcode;
        logic         [5:0] txcnt;
        logic               txtog;
    } regs_t;

    regs_t        q;
    regs_t        d;
    ep_rsp_if     rif ();
    logic         sel_ep;
    ep_pkg::tok_t sel_tok;
    logic   [7:0] sel_cnt;
    logic         req;
    logic         acc_wr;
    logic         acc_rd;
    logic         lock_mode;
    logic         lock_cnt;
    logic         upd;
    logic         rd_mode0;
    logic         rd_cnt0;
    logic   [7:0] rd_mux;

    // ------------------------------------------------------------
    // Decoder hookup
    // ------------------------------------------------------------
    assign sel_ep   = (q.st == ST_IDLE) ? tok_ep_i : q.ep;
    assign sel_tok  = (q.st == ST_IDLE) ? tok_pid_i : q.tok;
    assign sel_cnt  = sel_ep ? q.cnt1 : q.cnt0;
    assign rif.mode = sel_ep ? q.mode1[3:0] : q.mode0[3:0];
    assign rif.tok      = sel_tok;
    assign rif.stall    = sel_ep & q.mode1[ep_pkg::STALL_BIT];
    assign rif.ctrl     = ~sel_ep;
    assign rif.crc_ok   = crc_ok_i;
    assign rif.chk_ok   = (rx_count_i == ep_pkg::CRC_BYTES)
                          & rx_toggle_i;
    assign rif.host_ack = host_ack_i;

    mode_decoder u_dec (
        .d (rif.decoder)
    );

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    assign req    = avs_read_i | avs_write_i;
    assign acc_wr = avs_write_i & q.ack;
    assign acc_rd = avs_read_i & q.ack;
    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o    = {24'h000000, q.rdata};
    assign rd_mode0 = acc_rd && avs_address_i == ep_pkg::OFS_EP0_MODE;
    assign rd_cnt0  = acc_rd && avs_address_i == ep_pkg::OFS_EP0_CNT;
    assign upd = (q.st == ST_BUSY) && txn_end_i && rif.engaged;

    always_comb
    begin
        case (avs_address_i)
            ep_pkg::OFS_EP0_MODE: rd_mux = q.mode0;
            ep_pkg::OFS_EP0_CNT:  rd_mux = q.cnt0;
            ep_pkg::OFS_EP1_MODE: rd_mux = q.mode1;
            ep_pkg::OFS_EP1_CNT:  rd_mux = q.cnt1;
            ep_pkg::OFS_FLAGS:    rd_mux = {6'h00, q.flags};
            default:              rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Endpoint 0 locks
    // ------------------------------------------------------------
    reg_lock u_lock_mode (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .set_i    (upd & ~q.ep),
        .clear_i  (rd_mode0),
        .locked_o (lock_mode)
    );

    reg_lock u_lock_cnt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .set_i    (upd & ~q.ep),
        .clear_i  (rd_cnt0),
        .locked_o (lock_cnt)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.ack = 1'b0;
        d.rv = 1'b0;
        if (req && !q.ack)
        begin
            d.ack = 1'b1;
            d.rdata = rd_mux;
        end
        if (acc_wr && avs_byteenable_i[0])
        begin
            case (avs_address_i)
                ep_pkg::OFS_EP0_MODE:
                    if (!lock_mode)
                        d.mode0 = {1'b0, avs_writedata_i[6:0]};
                ep_pkg::OFS_EP0_CNT:
                    if (!lock_cnt)
                        d.cnt0 = avs_writedata_i[7:0];
                ep_pkg::OFS_EP1_MODE:
                    d.mode1 = avs_writedata_i[7:0];
                ep_pkg::OFS_EP1_CNT:
                    d.cnt1 = avs_writedata_i[7:0];
                ep_pkg::OFS_FLAGS:
                    d.flags = q.flags & ~avs_writedata_i[1:0];
                default:
                    d.ack = 1'b0;
            endcase
        end
        case (q.st)
            ST_IDLE:
            begin
                if (tok_valid_i)
                begin
                    d.st = ST_BUSY;
                    d.ep = tok_ep_i;
                    d.tok = tok_pid_i;
                    if (tok_pid_i == ep_pkg::TOK_IN)
                    begin
                        d.rv = (rif.rsp != ep_pkg::RSP_NONE);
                        d.rcode = rif.rsp;
                        d.txcnt = (rif.rsp == ep_pkg::RSP_DATA)
                                  ? sel_cnt[5:0] : 6'h00;
                        d.txtog = sel_cnt[ep_pkg::TOGGLE_BIT];
                    end
                end
            end
            ST_BUSY:
            begin
                if (data_start_i && q.tok == ep_pkg::TOK_SETUP && !q.ep
                    && rif.engaged)
                    d.hold = 1'b1;
                if (txn_end_i)
                begin
                    d.st = ST_IDLE;
                    d.hold = 1'b0;
                    if (q.tok != ep_pkg::TOK_IN)
                    begin
                        d.rv = (rif.rsp != ep_pkg::RSP_NONE);
                        d.rcode = rif.rsp;
                    end
                end
                if (upd && !q.ep)
                begin
                    d.mode0[6] = d.mode0[6] | (q.tok == ep_pkg::TOK_IN);
                    d.mode0[5] = d.mode0[5] | (q.tok == ep_pkg::TOK_OUT);
                    d.mode0[4] = d.mode0[4] | rif.acked;
                    d.mode0[3:0] = rif.next_mode;
                end
                if (upd && q.ep)
                begin
                    d.mode1[4] = d.mode1[4] | rif.acked;
                    d.mode1[3:0] = rif.next_mode;
                end
                if (upd && q.tok != ep_pkg::TOK_IN)
                begin
                    if (q.ep)
                        d.cnt1 = {rx_toggle_i, crc_ok_i, rx_count_i};
                    else
                        d.cnt0 = {rx_toggle_i, crc_ok_i, rx_count_i};
                end
                if (upd)
                    d.flags[q.ep] = 1'b1;
            end
            default:
                d.st = ST_IDLE;
        endcase
        if (d.hold)
            d.mode0[ep_pkg::SETUP_BIT] = 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.mode0 <= ep_pkg::REG_RESET;
            q.mode1 <= ep_pkg::REG_RESET;
        end
        else
            q <= d;
    end

    assign rsp_valid_o = q.rv;
    assign rsp_code_o  = q.rcode;
    assign tx_count_o  = q.txcnt;
    assign tx_toggle_o = q.txtog;
    assign ep_flag_o   = q.flags;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_setup_hold;
        q.hold |-> q.mode0[ep_pkg::SETUP_BIT];
    endproperty
    a_setup_hold: assert property (p_setup_hold)
        else $error("setup bit dropped during data phase");

    property p_locked_write;
        (acc_wr && avs_address_i == ep_pkg::OFS_EP0_CNT && lock_cnt
         && !upd) |=> $stable(q.cnt0);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("locked counter register took a write");

    property p_locked_mode;
        (acc_wr && avs_address_i == ep_pkg::OFS_EP0_MODE && lock_mode
         && !upd) |=> $stable(q.mode0[6:0]);
    endproperty
    a_locked_mode: assert property (p_locked_mode)
        else $error("locked mode register took a write");

    property p_unlock;
        (rd_mode0 && !upd) |=> !lock_mode;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("read did not unlock mode register");

    property p_lock_on_update;
        (upd && !q.ep) |=> lock_mode && lock_cnt;
    endproperty
    a_lock_on_update: assert property (p_lock_on_update)
        else $error("update left endpoint 0 unlocked");

    property p_count;
        (upd && !q.ep && q.tok != ep_pkg::TOK_IN) |=>
            q.cnt0 == {$past(rx_toggle_i), $past(crc_ok_i),
                       $past(rx_count_i)};
    endproperty
    a_count: assert property (p_count)
        else $error("counter register not refreshed");

    property p_flag;
        upd |=> q.flags[$past(q.ep)];
    endproperty
    a_flag: assert property (p_flag)
        else $error("endpoint flag not set at update");

    property p_disabled;
        (q.st == ST_BUSY && txn_end_i && rif.mode == ep_pkg::MODE_DISABLE)
            |=> !q.rv ##1 !q.rv;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled endpoint answered");

    property p_ack_out;
        (upd && q.ep && q.tok == ep_pkg::TOK_OUT
         && rif.mode == ep_pkg::MODE_ACK_OUT
         && rif.rsp == ep_pkg::RSP_ACK)
            |=> q.mode1[3:0] == ep_pkg::MODE_NAK_OUT;
    endproperty
    a_ack_out: assert property (p_ack_out)
        else $error("ACK OUT mode did not move to NAK OUT");

    property p_setup_force;
        (upd && !q.ep && q.tok == ep_pkg::TOK_SETUP
         && rif.rsp == ep_pkg::RSP_ACK)
            |=> q.mode0[3:0] == ep_pkg::MODE_NAK_IO && q.rv;
    endproperty
    a_setup_force: assert property (p_setup_force)
        else $error("SETUP did not force NAK in/out mode");
endmodule // ep_engine
`default_nettype wire

// ===== usb_host_model.sv
// Host side token source for the endpoint engine
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
    input  wire logic   clk_i,
    output ep_pkg::tok_t tok_pid_o,
    output logic        tok_valid_o,
    output logic        tok_ep_o,
    output logic        data_start_o,
    output logic        txn_end_o,
    output logic  [5:0] rx_count_o,
    output logic        rx_toggle_o,
    output logic        host_ack_o
);
    initial
    begin
        {tok_valid_o, tok_ep_o, data_start_o, txn_end_o} = 4'h0;
        {rx_count_o, rx_toggle_o, host_ack_o} = 8'h00;
        tok_pid_o = ep_pkg::TOK_OUT;
    end
    // One transaction; next token only after the end pulse
    task automatic send(input ep_pkg::tok_t p, input logic e,
                        input logic [5:0] n, input logic t, input logic h);
        tok_valid_o <= 1'b1;
        tok_pid_o <= p;
        tok_ep_o <= e;
        @(posedge clk_i);
        tok_valid_o <= 1'b0;
        data_start_o <= (p == ep_pkg::TOK_SETUP);
        @(posedge clk_i);
        data_start_o <= 1'b0;
        txn_end_o <= 1'b1;
        {rx_count_o, rx_toggle_o, host_ack_o} <= {n, t, h};
        @(posedge clk_i);
        txn_end_o <= 1'b0;
        {rx_count_o, rx_toggle_o, host_ack_o} <= ~{n, t, h};
        repeat (3) @(posedge clk_i);
    endtask
endmodule // usb_host_model
`default_nettype wire

// ===== usb_endpoint_mode_response_lock_test.sv
// Self-checking bench for the endpoint response and lock engine
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_mode_response_lock_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic crc_ok = 1'b1;
    logic [31:0] rdata;
    logic [7:0] q, last_rsp, last_tx;
    logic tok_valid, tok_ep, data_start, txn_end, rx_toggle, host_ack;
    logic [5:0] rx_count, tx_count;
    logic tx_toggle, rsp_valid, wq;
    logic [1:0] flag;
    ep_pkg::tok_t pid;
    ep_pkg::rsp_t code;
    int n_fail = 0;
    int num_checks = 0;
    always #4 clk_i = ~clk_i;
    ep_engine ep_engine_inst (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wq), .tok_valid_i(tok_valid), .tok_pid_i(pid),
        .tok_ep_i(tok_ep), .data_start_i(data_start), .txn_end_i(txn_end),
        .rx_count_i(rx_count), .rx_toggle_i(rx_toggle), .crc_ok_i(crc_ok),
        .host_ack_i(host_ack), .rsp_valid_o(rsp_valid), .rsp_code_o(code),
        .tx_count_o(tx_count), .tx_toggle_o(tx_toggle), .ep_flag_o(flag));
    usb_host_model usb_host_model_inst (.clk_i(clk_i), .tok_pid_o(pid),
        .tok_valid_o(tok_valid), .tok_ep_o(tok_ep),
        .data_start_o(data_start), .txn_end_o(txn_end),
        .rx_count_o(rx_count), .rx_toggle_o(rx_toggle),
        .host_ack_o(host_ack));
    // Capture every handshake or data answer
    always @(posedge clk_i)
        if (rsp_valid === 1'b1)
        begin
            last_rsp <= {5'h00, code};
            last_tx <= {tx_toggle, 1'b0, tx_count};
        end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Avalon cycle; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        int i;
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, d};
        for (i = 0; i < 20; i++)
        begin
            @(negedge clk_i);
            if (wq === 1'b0)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            wrap_up();
        end
        q = rdata[7:0];
        @(posedge clk_i);
        {avs_read_i, avs_write_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic t_ep1_out();
        bus(1, ep_pkg::OFS_EP1_MODE, 8'h89);
        usb_host_model_inst.send(ep_pkg::TOK_OUT, 1, 6'h02, 1, 0);
        chk("stalled out", last_rsp, 8'h03);
        bus(1, ep_pkg::OFS_EP1_MODE, 8'h09);
        bus(1, ep_pkg::OFS_FLAGS, 8'h03);
        usb_host_model_inst.send(ep_pkg::TOK_OUT, 1, 6'h02, 1, 0);
        chk("out ack", last_rsp, 8'h01);
        chk("ep1 flag", {7'h0, flag[1]}, 8'h01);
        bus(0, ep_pkg::OFS_EP1_MODE, 8'h00);
        chk("ep1 mode", {4'h0, q[3:0]}, 8'h08);
        bus(0, ep_pkg::OFS_EP1_CNT, 8'h00);
        chk("ep1 count", q, 8'hc2);
        usb_host_model_inst.send(ep_pkg::TOK_OUT, 1, 6'h02, 1, 0);
        chk("out nak", last_rsp, 8'h02);
        crc_ok <= 1'b0;
        last_rsp <= 8'hff;
        usb_host_model_inst.send(ep_pkg::TOK_OUT, 1, 6'h04, 0, 0);
        crc_ok <= 1'b1;
        chk("bad crc", last_rsp, 8'hff);
        bus(0, ep_pkg::OFS_EP1_CNT, 8'h00);
        chk("bad crc count", q, 8'h04);
    endtask
    task automatic t_ep0_setup();
        bus(1, ep_pkg::OFS_EP0_MODE, 8'h02);
        usb_host_model_inst.send(ep_pkg::TOK_SETUP, 0, 6'h0a, 0, 0);
        chk("setup ack", last_rsp, 8'h01);
        bus(1, ep_pkg::OFS_EP0_MODE, 8'h03);
        bus(0, ep_pkg::OFS_EP0_MODE, 8'h00);
        chk("locked mode", {4'h0, q[3:0]}, 8'h01);
        chk("setup bit", {7'h0, q[7]}, 8'h01);
        chk("ep0 flag", {7'h0, flag[0]}, 8'h01);
        bus(0, ep_pkg::OFS_EP0_CNT, 8'h00);
        chk("ep0 count", q, 8'h4a);
        bus(1, ep_pkg::OFS_EP0_MODE, 8'h03);
        bus(0, ep_pkg::OFS_EP0_MODE, 8'h00);
        chk("unlocked mode", q, 8'h03);
        usb_host_model_inst.send(ep_pkg::TOK_IN, 0, 6'h02, 1, 0);
        chk("in stall", last_rsp, 8'h03);
    endtask
    task automatic t_ep1_in();
        bus(1, ep_pkg::OFS_EP1_CNT, 8'h83);
        bus(1, ep_pkg::OFS_EP1_MODE, 8'h0d);
        usb_host_model_inst.send(ep_pkg::TOK_IN, 1, 6'h02, 0, 1);
        chk("in data", last_rsp, 8'h04);
        chk("tx count", last_tx, 8'h83);
        bus(0, ep_pkg::OFS_EP1_MODE, 8'h00);
        chk("nak in mode", {4'h0, q[3:0]}, 8'h0c);
        usb_host_model_inst.send(ep_pkg::TOK_IN, 1, 6'h02, 0, 1);
        chk("in nak", last_rsp, 8'h02);
    endtask
    task automatic t_disabled();
        bus(0, ep_pkg::OFS_EP0_MODE, 8'h00);
        bus(1, ep_pkg::OFS_EP0_MODE, 8'h00);
        last_rsp <= 8'hff;
        usb_host_model_inst.send(ep_pkg::TOK_OUT, 0, 6'h02, 1, 0);
        chk("silent", last_rsp, 8'hff);
        bus(0, 5'h14, 8'h00);
        chk("unmapped", q, 8'h00);
    endtask
    initial
    begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, ep_pkg::OFS_EP1_MODE, 8'h00);
        chk("reset mode", q, 8'h00);
        t_ep1_out();
        t_ep0_setup();
        t_ep1_in();
        t_disabled();
        wrap_up();
    end
endmodule // usb_endpoint_mode_response_lock_test
`default_nettype wire
